// >>> rtl/ddr_module_pkg.sv
// Shared constants for the registered DDR module command and burst logic.
package ddr_module_pkg;
  localparam int ROW_W = 13;
  localparam int BA_W = 2;
  localparam int BANKS = 4;
  localparam int COL_W = 12;
  localparam int MODE_W = 13;
  // Command codes as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RESET = 4'hf;
  // Mode register field layout.
  localparam int BL_LSB = 0;
  localparam int ORDER_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int OPM_LSB = 7;
  localparam int DLL_RST_BIT = 8;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_25 = 3'h6;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [5:0] OPM_NORMAL = 6'h00;
  localparam logic [5:0] OPM_DLL_RST = 6'h02;
  localparam logic [MODE_W-1:0] MODE_RST = 13'h0000;
  // Read latency in half clocks of the link clock.
  localparam logic [2:0] HALF_CL_2 = 3'h4;
  localparam logic [2:0] HALF_CL_25 = 3'h5;
  localparam logic [2:0] HALF_CL_3 = 3'h6;
  // Presence-detect store.
  localparam int SPD_BYTES = 256;
  localparam logic [7:0] SPD_USER_BASE = 8'h80;
  localparam logic [3:0] SPD_DEV_TYPE = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : ddr_module_pkg

// >>> rtl/spd_store.sv
// Presence-detect byte store with a registered read port.
`timescale 1ns/10ps
module spd_store #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("spd_store: depth does not fit the address width");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : spd_store

// >>> rtl/burst_col_gen.sv
// Column address of one beat inside a wrapped burst block.
`timescale 1ns/10ps
module burst_col_gen #(
  parameter int COL_W = 12
) (
  input wire logic [COL_W-1:0] start_col,
  input wire logic [2:0] beat,
  input wire logic [2:0] mask,
  input wire logic interleave,
  output logic [COL_W-1:0] col
);
  logic [2:0] low;

  always_comb begin
    if (interleave) begin
      low = (start_col[2:0] ^ beat) & mask;
    end else begin
      low = (start_col[2:0] + beat) & mask;
    end
    // Upper bits select the block; only the low bits wrap.
    col = {start_col[COL_W-1:3], (start_col[2:0] & ~mask) | low};
  end
endmodule : burst_col_gen

// >>> rtl/ddr_reg_module.sv
// Registered DDR module: command redrive, mode, bursts and presence detect.
// How it works
// - Commands captured on differential clock rising crossing
// - One wide core word becomes two pin halves
// - Strobe driven on reads, received on writes
// - Read strobe edges align with data edges
// - Write data sampled on both strobe edges
// - Registered bank and column pick burst target
// - Burst length 2, 4 or 8, both orders
// - Auto precharge closes row after burst ends
// - Commands forwarded one link clock later
// - 256 byte store, lower half maker area
// - I2C target, straps pick one of eight
// - No hardware write protect on the store
// - Mode register set with bank bits zero, kept
// - DLL reset bit clears itself after write
// - Mode rewrite leaves array data untouched
// - Mode fields: length, order, latency, op mode
// - Burst wraps inside aligned block of burst length
// - Order bit picks sequential or interleaved
// - Four banks tracked independently
// - Sequential adds, interleaved XORs inside block
// - Read latency 2, 2.5 or 3 clocks
// - Op mode zero normal, A8 alone DLL reset
`timescale 1ns/10ps
module ddr_reg_module
  import ddr_module_pkg::*;
#(
  parameter int DQ_W = 72,
  parameter bit LARGE_DENSITY = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [ddr_module_pkg::BA_W-1:0] ba,
  input wire logic [ddr_module_pkg::ROW_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe,
  output logic r_cs_n,
  output logic r_ras_n,
  output logic r_cas_n,
  output logic r_we_n,
  output logic r_cke,
  output logic [ddr_module_pkg::BA_W-1:0] r_ba,
  output logic [ddr_module_pkg::ROW_W-1:0] r_addr,
  output logic core_rd,
  output logic core_wr,
  output logic [ddr_module_pkg::BA_W-1:0] core_bank,
  output logic [ddr_module_pkg::ROW_W-1:0] core_row,
  output logic [ddr_module_pkg::COL_W-1:0] core_col,
  output logic [2*DQ_W-1:0] core_wdata,
  input wire logic [2*DQ_W-1:0] core_rdata,
  output logic auto_pre,
  output logic [ddr_module_pkg::BANKS-1:0] bank_open,
  output logic access_closed_err,
  output logic [ddr_module_pkg::MODE_W-1:0] mode_bits,
  output logic mode_reserved,
  output logic dll_reset_pulse,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] presence_target_address_straps,
  input wire logic spd_maker_unlock
);
  import ddr_module_pkg::*;

  if (DQ_W < 1) begin : g_bad_width
    $error("ddr_reg_module: DQ_W must be at least one");
  end

  function automatic logic [2:0] bl_mask(input logic [2:0] code);
    case (code)
      BL_2: bl_mask = 3'h1;
      BL_4: bl_mask = 3'h3;
      BL_8: bl_mask = 3'h7;
      default: bl_mask = 3'h1;
    endcase
  endfunction : bl_mask

  function automatic logic [2:0] cl_half(input logic [2:0] code);
    case (code)
      CL_2: cl_half = HALF_CL_2;
      CL_25: cl_half = HALF_CL_25;
      CL_3: cl_half = HALF_CL_3;
      default: cl_half = HALF_CL_3;
    endcase
  endfunction : cl_half

  function automatic logic [COL_W-1:0] col_of(input logic [ROW_W-1:0] a);
    col_of = {a[12] & LARGE_DENSITY, a[11], a[9:0]};
  endfunction : col_of

  localparam int SW = 29 + DQ_W;

  // Link, strap and I2C pins cross into clk through two flops; only sync_r reads meta_r.
  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= SW'(3) << (DQ_W + 23);
      sync_r <= SW'(3) << (DQ_W + 23);
    end else begin
      meta_r <= {spd_maker_unlock, presence_target_address_straps, sda_i,
                 scl, dq_i, dqs_i, addr, ba, cke, we_n, cas_n, ras_n,
                 cs_n, ck_n, ck};
      sync_r <= meta_r;
    end
  end

  logic ck_hi;
  logic [3:0] s_cmd;
  logic s_cke;
  logic [BA_W-1:0] s_ba;
  logic [ROW_W-1:0] s_addr;
  logic s_dqs;
  logic [DQ_W-1:0] s_dq;
  logic s_scl;
  logic s_sda;
  logic [2:0] s_straps;
  logic s_unlock;

  assign ck_hi = sync_r[0] & ~sync_r[1];
  assign s_cmd = {sync_r[2], sync_r[3], sync_r[4], sync_r[5]};
  assign s_cke = sync_r[6];
  assign s_ba = sync_r[8:7];
  assign s_addr = sync_r[21:9];
  assign s_dqs = sync_r[22];
  assign s_dq = sync_r[23 +: DQ_W];
  assign s_scl = sync_r[DQ_W+23];
  assign s_sda = sync_r[DQ_W+24];
  assign s_straps = sync_r[DQ_W+27:DQ_W+25];
  assign s_unlock = sync_r[DQ_W+28];

  logic ck_hi_d_r;
  logic dqs_d_r;
  logic ck_rise;
  logic half_edge;
  logic dqs_rise;
  logic dqs_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_hi_d_r <= 1'b0;
      dqs_d_r <= 1'b0;
    end else begin
      ck_hi_d_r <= ck_hi;
      dqs_d_r <= s_dqs;
    end
  end

  assign ck_rise = ck_hi & ~ck_hi_d_r;
  assign half_edge = ck_hi ^ ck_hi_d_r;
  assign dqs_rise = s_dqs & ~dqs_d_r;
  assign dqs_fall = ~s_dqs & dqs_d_r;

  // Two register stages: latch on one rising edge, drive on the next.
  logic [3:0] cap_cmd_r;
  logic cap_cke_r;
  logic [BA_W-1:0] cap_ba_r;
  logic [ROW_W-1:0] cap_addr_r;
  logic cmd_go_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_cmd_r <= CMD_RESET;
      cap_cke_r <= 1'b0;
      cap_ba_r <= '0;
      cap_addr_r <= '0;
      {r_cs_n, r_ras_n, r_cas_n, r_we_n} <= CMD_RESET;
      r_cke <= 1'b0;
      r_ba <= '0;
      r_addr <= '0;
      cmd_go_r <= 1'b0;
    end else begin
      cmd_go_r <= ck_rise;
      if (ck_rise) begin
        cap_cmd_r <= s_cmd;
        cap_cke_r <= s_cke;
        cap_ba_r <= s_ba;
        cap_addr_r <= s_addr;
        {r_cs_n, r_ras_n, r_cas_n, r_we_n} <= cap_cmd_r;
        r_cke <= cap_cke_r;
        r_ba <= cap_ba_r;
        r_addr <= cap_addr_r;
      end
    end
  end

  logic [3:0] r_cmd;
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic is_mrs;
  logic tgt_open;
  logic go_rd;
  logic go_wr;

  assign r_cmd = {r_cs_n, r_ras_n, r_cas_n, r_we_n};
  assign is_act = cmd_go_r & r_cke & (r_cmd == CMD_ACT);
  assign is_pre = cmd_go_r & r_cke & (r_cmd == CMD_PRE);
  assign is_rd = cmd_go_r & r_cke & (r_cmd == CMD_RD);
  assign is_wr = cmd_go_r & r_cke & (r_cmd == CMD_WR);
  assign is_mrs = cmd_go_r & r_cke & (r_cmd == CMD_MRS);
  assign tgt_open = bank_open[r_ba];
  assign go_rd = is_rd & tgt_open;
  assign go_wr = is_wr & tgt_open;

  // Mode register; only register state changes, never the array.
  logic [MODE_W-1:0] mode_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
      dll_reset_pulse <= 1'b0;
    end else begin
      dll_reset_pulse <= 1'b0;
      if (is_mrs && r_ba == '0) begin
        mode_r <= r_addr & ~(MODE_W'(1) << DLL_RST_BIT);
        dll_reset_pulse <= r_addr[DLL_RST_BIT];
      end
    end
  end

  assign mode_bits = mode_r;
  assign mode_reserved = (mode_r[OPM_LSB +: 6] != OPM_NORMAL) &&
                         (mode_r[OPM_LSB +: 6] != OPM_DLL_RST);

  // Burst sequencing for reads and writes.
  logic bst_active_r;
  logic bst_write_r;
  logic [BA_W-1:0] bst_bank_r;
  logic [COL_W-1:0] bst_start_r;
  logic bst_ap_r;
  logic [2:0] bst_mask_r;
  logic bst_ilv_r;
  logic [2:0] beat_r;
  logic [3:0] idx_r;
  logic [2:0] wait_r;
  logic fetch_r;
  logic post_r;
  logic stream_edge;
  logic rd_done;
  logic wr_beat;
  logic wr_done;
  logic [COL_W-1:0] gen_col;

  assign stream_edge = bst_active_r & ~bst_write_r & half_edge &
                       (wait_r == 3'h1);
  assign rd_done = stream_edge & idx_r[0] & (idx_r[3:1] == bst_mask_r);
  assign wr_beat = bst_active_r & bst_write_r & dqs_fall;
  assign wr_done = wr_beat & (beat_r == bst_mask_r);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bst_active_r <= 1'b0;
      bst_write_r <= 1'b0;
      bst_bank_r <= '0;
      bst_start_r <= '0;
      bst_ap_r <= 1'b0;
      bst_mask_r <= '0;
      bst_ilv_r <= 1'b0;
      beat_r <= '0;
      idx_r <= '0;
      wait_r <= '0;
      fetch_r <= 1'b0;
      post_r <= 1'b0;
    end else begin
      fetch_r <= 1'b0;
      if (go_rd || go_wr) begin
        bst_active_r <= 1'b1;
        bst_write_r <= go_wr;
        bst_bank_r <= r_ba;
        bst_start_r <= col_of(r_addr);
        bst_ap_r <= r_addr[AP_BIT];
        bst_mask_r <= bl_mask(mode_r[BL_LSB +: 3]);
        bst_ilv_r <= mode_r[ORDER_BIT];
        beat_r <= '0;
        idx_r <= '0;
        wait_r <= cl_half(mode_r[CL_LSB +: 3]);
        fetch_r <= go_rd;
        post_r <= 1'b0;
      end else if (bst_active_r && !bst_write_r) begin
        if (fetch_r) begin
          beat_r <= beat_r + 3'h1;
        end
        if (half_edge && wait_r != 3'h1) begin
          wait_r <= wait_r - 3'h1;
        end
        if (stream_edge) begin
          idx_r <= idx_r + 4'h1;
          if (rd_done) begin
            bst_active_r <= 1'b0;
            post_r <= 1'b1;
          end else if (idx_r[0]) begin
            fetch_r <= 1'b1;
          end
        end
      end else if (wr_beat) begin
        beat_r <= beat_r + 3'h1;
        if (wr_done) begin
          bst_active_r <= 1'b0;
        end
      end else if (post_r && half_edge) begin
        post_r <= 1'b0;
      end
    end
  end

  burst_col_gen #(
    .COL_W(COL_W)
  ) u_col (
    .start_col(bst_start_r),
    .beat(beat_r),
    .mask(bst_mask_r),
    .interleave(bst_ilv_r),
    .col(gen_col)
  );

  // Bank state; each bank opens and closes on its own, except precharge with A10 closes all.
  logic [ROW_W-1:0] open_row_r [BANKS];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_open <= '0;
      access_closed_err <= 1'b0;
      auto_pre <= 1'b0;
      for (int b = 0; b < BANKS; b++) begin
        open_row_r[b] <= '0;
      end
    end else begin
      access_closed_err <= (is_rd | is_wr) & ~tgt_open;
      auto_pre <= (rd_done | wr_done) & bst_ap_r;
      for (int b = 0; b < BANKS; b++) begin
        if (is_act && r_ba == BA_W'(b)) begin
          bank_open[b] <= 1'b1;
          open_row_r[b] <= r_addr;
        end else if (is_pre && (r_addr[AP_BIT] || r_ba == BA_W'(b))) begin
          bank_open[b] <= 1'b0;
        end else if ((rd_done | wr_done) && bst_ap_r &&
                     bst_bank_r == BA_W'(b)) begin
          bank_open[b] <= 1'b0;
        end
      end
    end
  end

  // Core side: one wide word per beat.
  logic [DQ_W-1:0] wlo_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_rd <= 1'b0;
      core_wr <= 1'b0;
      core_bank <= '0;
      core_row <= '0;
      core_col <= '0;
      core_wdata <= '0;
      wlo_r <= '0;
    end else begin
      core_rd <= fetch_r;
      core_wr <= wr_beat;
      if (fetch_r || wr_beat) begin
        core_col <= gen_col;
        core_bank <= bst_bank_r;
        core_row <= open_row_r[bst_bank_r];
      end
      if (bst_active_r && bst_write_r && dqs_rise) begin
        wlo_r <= s_dq;
      end
      if (wr_beat) begin
        core_wdata <= {s_dq, wlo_r};
      end
    end
  end

  // Pin side of reads: half words on each link clock edge.
  logic [2*DQ_W-1:0] rd_next_r;
  logic [DQ_W-1:0] rd_hi_r;
  logic drv_oe_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_next_r <= '0;
      rd_hi_r <= '0;
      dq_o <= '0;
      dqs_o <= 1'b0;
      drv_oe_r <= 1'b0;
    end else begin
      if (core_rd) begin
        rd_next_r <= core_rdata;
      end
      if (stream_edge) begin
        drv_oe_r <= 1'b1;
        if (!idx_r[0]) begin
          dq_o <= rd_next_r[DQ_W-1:0];
          rd_hi_r <= rd_next_r[2*DQ_W-1:DQ_W];
          dqs_o <= 1'b1;
        end else begin
          dq_o <= rd_hi_r;
          dqs_o <= 1'b0;
        end
      end else if (post_r && half_edge) begin
        drv_oe_r <= 1'b0;
      end
    end
  end

  assign dq_oe = drv_oe_r;
  assign dqs_oe = drv_oe_r;

  // Presence-detect I2C target.
  typedef enum logic [3:0] {
    I_IDLE = 4'h0,
    I_DEV = 4'h1,
    I_DACK = 4'h3,
    I_WADR = 4'h2,
    I_AACK = 4'h6,
    I_WDAT = 4'h7,
    I_WACK = 4'h5,
    I_RDAT = 4'h4,
    I_RACK = 4'hc
  } i2c_state_e;

  i2c_state_e ist_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic nack_r;
  logic mem_we;
  logic [7:0] mem_q;
  logic i_start;
  logic i_stop;
  logic scl_rise;
  logic scl_fall;
  logic byte_in;

  assign i_start = s_scl & scl_d_r & sda_d_r & ~s_sda;
  assign i_stop = s_scl & scl_d_r & ~sda_d_r & s_sda;
  assign scl_rise = s_scl & ~scl_d_r;
  assign scl_fall = ~s_scl & scl_d_r;
  assign byte_in = scl_fall & (bit_cnt_r == BITS_PER_BYTE);
  // No write-protect pin exists, so only the maker area gate applies.
  assign mem_we = (ist_r == I_WDAT) & byte_in &
                  (ptr_r >= SPD_USER_BASE | s_unlock);
  assign sda_o = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ist_r <= I_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_cnt_r <= '0;
      sh_r <= '0;
      ptr_r <= '0;
      nack_r <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_d_r <= s_scl;
      sda_d_r <= s_sda;
      if (scl_rise && (ist_r == I_DEV || ist_r == I_WADR ||
                       ist_r == I_WDAT)) begin
        sh_r <= {sh_r[6:0], s_sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (i_start) begin
        ist_r <= I_DEV;
        bit_cnt_r <= '0;
        sda_oe <= 1'b0;
      end else if (i_stop) begin
        ist_r <= I_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (ist_r)
          I_DEV: begin
            if (byte_in) begin
              if (sh_r[7:1] == {SPD_DEV_TYPE, s_straps}) begin
                sda_oe <= 1'b1;
                nack_r <= sh_r[0];
                ist_r <= I_DACK;
              end else begin
                ist_r <= I_IDLE;
              end
            end
          end
          I_DACK, I_RACK: begin
            if (scl_rise && ist_r == I_RACK) begin
              nack_r <= ~s_sda;
            end
            if (scl_fall) begin
              bit_cnt_r <= '0;
              sda_oe <= 1'b0;
              if (!nack_r) begin
                ist_r <= (ist_r == I_DACK) ? I_WADR : I_IDLE;
              end else begin
                sda_oe <= ~mem_q[7];
                sh_r <= {mem_q[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                ist_r <= I_RDAT;
              end
            end
          end
          I_RDAT: begin
            if (scl_fall) begin
              if (bit_cnt_r == BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
                ist_r <= I_RACK;
              end else begin
                sda_oe <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          I_WADR, I_WDAT: begin
            if (byte_in) begin
              ptr_r <= (ist_r == I_WADR) ? sh_r : ptr_r + 8'h01;
              sda_oe <= 1'b1;
              ist_r <= (ist_r == I_WADR) ? I_AACK : I_WACK;
            end
          end
          I_AACK, I_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt_r <= '0;
              ist_r <= I_WDAT;
            end
          end
          default: ist_r <= I_IDLE;
        endcase
      end
    end
  end

  spd_store #(
    .DEPTH(SPD_BYTES),
    .AW(8)
  ) u_spd (
    .clk(clk),
    .we(mem_we),
    .addr(ptr_r),
    .wdata(sh_r),
    .rdata(mem_q)
  );
endmodule : ddr_reg_module

// >>> test/ddr_reg_module_asserts.sv
// Port-level concurrent checks for the registered DDR module.
`timescale 1ns/10ps
module ddr_reg_module_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic r_cs_n,
  input wire logic r_ras_n,
  input wire logic r_cas_n,
  input wire logic r_we_n,
  input wire logic [ddr_module_pkg::BA_W-1:0] r_ba,
  input wire logic [ddr_module_pkg::ROW_W-1:0] r_addr,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic core_rd,
  input wire logic core_wr,
  input wire logic [ddr_module_pkg::BA_W-1:0] core_bank,
  input wire logic auto_pre,
  input wire logic [ddr_module_pkg::BANKS-1:0] bank_open,
  input wire logic [ddr_module_pkg::MODE_W-1:0] mode_bits,
  input wire logic dll_reset_pulse
);
  import ddr_module_pkg::*;
  logic ck_r;
  logic [3:0] rise_age_r;
  wire [3:0] r_cmd = {r_cs_n, r_ras_n, r_cas_n, r_we_n};
  wire dll_bit = r_addr[DLL_RST_BIT];
  always_ff @(posedge clk) begin
    ck_r <= ck;
  end
  // Cycles since the raw link clock rose; redrive must follow a rise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_age_r <= 4'hf;
    end else if (ck && !ck_r) begin
      rise_age_r <= 4'h0;
    end else if (rise_age_r != 4'hf) begin
      rise_age_r <= rise_age_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence mrs_prev;
    $past(r_cmd) == CMD_MRS && $past(r_ba) == 2'h0;
  endsequence
  AST_REDRIVE_ON_RISE: assert property ($changed({r_cmd, r_ba, r_addr})
    |-> rise_age_r >= 4'h1 && rise_age_r <= 4'h7) else $error("late redrive");
  AST_OE_PAIR: assert property ($rose(dqs_oe) |-> dq_oe && dqs_o)
    else $error("strobe enable without data or strobe high");
  AST_DLL_SELF_CLEAR: assert property (mode_bits[DLL_RST_BIT] == 1'b0)
    else $error("dll reset bit kept");
  AST_DLL_CAUSE: assert property (dll_reset_pulse |-> mrs_prev
    ##0 $past(dll_bit) ##1 !dll_reset_pulse) else $error("bad dll pulse");
  AST_MODE_SOURCE: assert property ($changed(mode_bits) |-> mrs_prev)
    else $error("mode changed without mode set");
  AST_CORE_EXCL: assert property (!(core_rd && core_wr))
    else $error("fetch and store together");
  AST_RD_OPEN_BANK: assert property (core_rd |-> bank_open[core_bank]
    ##1 !core_rd) else $error("fetch from closed bank");
  AST_AP_PULSE: assert property (auto_pre |=> !auto_pre)
    else $error("precharge pulse too long");
  AST_STROBE_IN_BURST: assert property ($changed(dqs_o)
    |-> dq_oe || $past(dq_oe)) else $error("strobe moved outside burst");
endmodule : ddr_reg_module_asserts
bind ddr_reg_module ddr_reg_module_asserts u_chk (.clk, .rst_n, .ck,
  .r_cs_n, .r_ras_n, .r_cas_n, .r_we_n, .r_ba, .r_addr, .dq_oe, .dqs_o,
  .dqs_oe, .core_rd, .core_wr, .core_bank, .auto_pre, .bank_open,
  .mode_bits, .dll_reset_pulse);

// >>> test/ddr_host_model.sv
// Memory controller model: free-running link clock, commands, write data.
`timescale 1ns/10ps
module ddr_host_model (
  input wire logic clk,
  output logic ck,
  output logic ck_n,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cke,
  output logic [ddr_module_pkg::BA_W-1:0] ba,
  output logic [ddr_module_pkg::ROW_W-1:0] addr,
  output logic [71:0] dq_i,
  output logic dqs_i
);
  import ddr_module_pkg::*;
  initial begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n, cke} = 5'h1f;
    ba = 2'h0;
    addr = 13'h0;
    dq_i = 72'h0;
    dqs_i = 1'b0;
  end
  always #40 ck = ~ck;
  assign ck_n = ~ck;
  // One command per link clock, then deselect with inverted address so a
  // stale sample of the bus cannot pass for the real one.
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a);
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= CMD_RESET;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd
  // Strobe edges sit mid-window, six clocks from each data change.
  task automatic wr(input int n, input logic [143:0] d [8]);
    @(posedge ck);
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      dq_i <= d[i][71:0];
      repeat (6) @(posedge clk);
      dqs_i <= 1'b1;
      repeat (6) @(posedge clk);
      dq_i <= d[i][143:72];
      repeat (6) @(posedge clk);
      dqs_i <= 1'b0;
      repeat (6) @(posedge clk);
    end
    dq_i <= ~dq_i;
  endtask : wr
endmodule : ddr_host_model

// >>> test/registered_ddr_module_mode_burst_bench.sv
// Self-checking bench for the registered DDR module.
`timescale 1ns/10ps
module registered_ddr_module_mode_burst_bench;
  import ddr_module_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ck, ck_n, cs_n, ras_n, cas_n, we_n, cke, dqs_i, dq_oe, dqs_o;
  logic dqs_oe, r_cs_n, r_ras_n, r_cas_n, r_we_n, r_cke, core_rd, core_wr;
  logic auto_pre, access_closed_err, mode_reserved, dll_reset_pulse;
  logic sda_o, sda_oe, dqs_q;
  logic scl = 1'b1, sda = 1'b1, hf = 1'b0;
  logic [7:0] dv;
  logic [1:0] ba, r_ba, core_bank, b;
  logic [12:0] addr, r_addr, core_row, mode_bits, mode, mexp, row;
  logic [71:0] dq_i, dq_o;
  logic [11:0] core_col, sc;
  logic [143:0] core_wdata, rdw;
  logic [143:0] core_rdata = '0;
  logic [143:0] wd [8];
  logic [3:0] bank_open;
  logic [2:0] straps = 3'h0;
  logic [2:0] cl_tab [3] = '{CL_2, CL_25, CL_3};
  logic [175:0] obs, want;
  logic [175:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int bl;
  always #4 clk = ~clk;
  ddr_reg_module dut (.clk, .rst_n, .ck, .ck_n, .cs_n, .ras_n, .cas_n,
    .we_n, .cke, .ba, .addr, .dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe,
    .r_cs_n, .r_ras_n, .r_cas_n, .r_we_n, .r_cke, .r_ba, .r_addr, .core_rd,
    .core_wr, .core_bank, .core_row, .core_col, .core_wdata, .core_rdata,
    .auto_pre, .bank_open, .access_closed_err, .mode_bits, .mode_reserved,
    .dll_reset_pulse, .scl, .sda_i(sda), .sda_o, .sda_oe,
    .presence_target_address_straps(straps), .spd_maker_unlock(1'b0));
  ddr_host_model host (.clk, .ck, .ck_n, .cs_n, .ras_n, .cas_n, .we_n,
    .cke, .ba, .addr, .dq_i, .dqs_i);
  task automatic check(input logic [175:0] seen, input logic [175:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic settle;
    @(posedge ck);
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic i2c_bit(input logic v);
    repeat (6) @(posedge clk);
    sda <= v;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    repeat (12) @(posedge clk);
    scl <= 1'b0;
  endtask : i2c_bit
  function automatic logic [11:0] beat_col(logic [11:0] s, int i, int n,
    logic il);
    logic [2:0] m, lo;
    m = 3'(n - 1);
    lo = il ? (s[2:0] ^ 3'(i)) : (s[2:0] + 3'(i));
    return (s & ~{9'h0, m}) | {9'h0, lo & m};
  endfunction : beat_col
  always @(posedge clk) begin
    core_rdata <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  // Every core event or pulse takes the oldest note; extra events mismatch.
  always @(posedge clk) begin
    if (rst_n && (core_rd | core_wr | dll_reset_pulse | access_closed_err |
      auto_pre)) begin
      obs = {core_rd, core_wr, dll_reset_pulse, access_closed_err, auto_pre,
        (core_rd | core_wr) ? {core_bank, core_row, core_col} : 27'h0,
        core_wr ? core_wdata : 144'h0};
      want = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      check(obs, want);
    end
    if (core_rd) rdw = core_rdata;
    if (dq_oe && dqs_o != dqs_q) begin
      check(176'({dqs_o, dq_o}),
        176'({!hf, hf ? rdw[143:72] : rdw[71:0]}));
      hf = !hf;
    end
    dqs_q = dqs_o;
  end
  initial begin
    void'($urandom(79));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      bl = 2 << (i % 3);
      b = 2'(i);
      mode = {4'h0, 1'(i == 0), 1'b0, cl_tab[(i + 1) % 3], 1'(i > 2),
        3'(i % 3 + 1)};
      mexp = mode & ~13'h100;
      host.cmd(CMD_MRS, 2'h0, mode);
      if (i == 0) exp_q.push_back({5'h04, 171'h0});
      settle();
      check({144'h0, r_cs_n, r_ras_n, r_cas_n, r_we_n, r_ba, r_addr,
        mode_bits}, {144'h0, CMD_MRS, 2'h0, mode, mexp});
      row = 13'($urandom);
      sc = 12'($urandom);
      straps <= 3'($urandom);
      host.cmd(CMD_ACT, b, row);
      host.cmd(CMD_RD, b, {sc[11:10], 1'b0, sc[9:0]});
      for (int k = 0; k < bl; k++) begin
        exp_q.push_back({5'h10, b, row, beat_col(sc, k, bl, i > 2),
          144'h0});
      end
      wait (exp_q.size() == 0);
      settle();
      settle();
      for (int k = 0; k < 8; k++) begin
        wd[k] = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      end
      host.cmd(CMD_WR, b, {sc[11:10], 1'b1, sc[9:0]});
      for (int k = 0; k < bl; k++) begin
        exp_q.push_back({4'h4, 1'(k == bl - 1), b, row,
          beat_col(sc, k, bl, i > 2), wd[k]});
      end
      host.wr(bl, wd);
      wait (exp_q.size() == 0);
      host.cmd(CMD_RD, b, 13'h0);
      exp_q.push_back({5'h02, 171'h0});
      wait (exp_q.size() == 0);
      settle();
      $display("burst test %0d done", i);
    end
    host.cmd(CMD_MRS, 2'h1, 13'($urandom));
    settle();
    check({163'h0, mode_bits}, {163'h0, mexp});
    $display("mode bank test done");
    dv = {SPD_DEV_TYPE, straps, 1'b0};
    sda <= 1'b0;
    repeat (12) @(posedge clk);
    scl <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      i2c_bit(dv[k]);
    end
    repeat (8) @(posedge clk);
    check(176'(sda_oe), 176'(1'b1));
    $display("presence detect test done");
    final_report();
  end
endmodule : registered_ddr_module_mode_burst_bench
